// ===== design/wsc_watchdog.sv
// watchdog timer, shared prescaler, sleep control and configuration word
`timescale 1ns/1ps
// Functional notes
// R01 - config bits 11..3 are code protection; one leaves memory readable, zero protects
// R02 - config bit 2 enables the watchdog when one, keeps it idle when zero
// R03 - oscillator field decodes 00 LP, 01 XT, 10 HS, 11 RC
// R04 - watchdog counts from its own free-running time base, also during sleep
// R05 - watchdog time-out forces a full device reset, running or asleep
// R06 - watchdog time-out reset clears the active-low time-out flag, status bit 4
// R07 - watchdog disabled by fuse stays disabled; nothing at run time re-enables it
// R08 - one 8-bit prescaler serves either the general timer or the watchdog
// R09 - option bits 3..0 select prescaler assignment and division ratio
// R10 - base time-out 18 ms, lengthened up to 1:128 with the prescaler
// R11 - watchdog clear instruction resets counter and, if assigned, the prescaler
// R12 - sleep instruction resets counter and, if assigned, the prescaler
// R13 - sleep entry sets time-out flag, clears power-down flag, stops oscillator driver
// R14 - during sleep every I/O port holds its prior level and drive
// R15 - watchdog reset is internal only; master clear pin is never pulled low
// R16 - prescaler assign zero selects general timer, one selects watchdog
// R17 - any reset loads the prescaler with all zeros
// R18 - waking from sleep clears the watchdog counter whatever the cause
// R19 - with the watchdog assigned, ratio n divides time-outs by two to the n
module wsc_watchdog #(
    parameter int unsigned WDT_BASE = wsc_pkg::WDT_BASE_CYCLES,
    parameter bit MULTI_PROTECT = 1'b1,
    parameter int IO_W = 8
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [wsc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [wsc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [wsc_pkg::DATA_W-1:0] rdata_o,
    input wire logic watchdog_clear_instr_instr_i,
    input wire logic sleep_instr_i,
    input wire logic tmr_src_tick_i,
    input wire logic tmr_write_i,
    output logic tmr_inc_o,
    input wire logic master_clear_pin_i,
    output logic master_clear_pin_o,
    output logic master_clear_pin_oe_o,
    input wire logic [IO_W-1:0] port_out_i,
    input wire logic [IO_W-1:0] port_oe_i,
    output logic [IO_W-1:0] port_out_o,
    output logic [IO_W-1:0] port_oe_o,
    output logic device_reset_o,
    output logic sleeping_o,
    output logic osc_drv_en_o,
    output wsc_pkg::wsc_osc_t osc_type_select_o,
    output logic code_protect_o,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [wsc_pkg::CFG_W-1:0] cfg;
    logic cfg_locked;
    logic [wsc_pkg::OPT_W-1:0] option_control;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic [wsc_pkg::IRQ_W-1:0] irq_stat;
    logic [wsc_pkg::IRQ_W-1:0] irq_mask;
    logic [wsc_pkg::WDT_CNT_W-1:0] base_cnt;
    logic [wsc_pkg::PSC_W-1:0] psc;
    wsc_pkg::wsc_state_t state;
    logic master_clear_pin_sync;
    logic master_clear_pin_prev;
    logic master_clear_pin_fall;
    logic watchdog_enable_fuse;
    logic prescaler_assign;
    logic [2:0] prescale_ratio;
    logic [wsc_pkg::PSC_W-1:0] wdt_mask;
    logic [wsc_pkg::PSC_W-1:0] tmr_mask;
    logic base_tick;
    logic wdt_timeout;
    logic sleep_entry;
    logic wake;
    logic any_reset;
    logic wdt_clear;
    logic [wsc_pkg::IRQ_W-1:0] irq_event;
    logic [wsc_pkg::PSC_W:0] ticks_seen;

    ////////////////////////////////////////////////////////////////////////////
    // master clear pin input, never driven
    wsc_sync2 #(.RESET_VAL(1'b1)) u_master_clear_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .async_i(master_clear_pin_i),
        .sync_o(master_clear_pin_sync)
    );

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            master_clear_pin_prev <= 1'b1;
        end else begin
            master_clear_pin_prev <= master_clear_pin_sync;
        end
    end

    assign master_clear_pin_fall = master_clear_pin_prev && !master_clear_pin_sync;
    assign master_clear_pin_o = 1'b0;
    assign master_clear_pin_oe_o = 1'b0; // see R15

    ////////////////////////////////////////////////////////////////////////////
    // configuration decode
    assign watchdog_enable_fuse = cfg[wsc_pkg::CFG_WATCHDOG_ENABLE_FUSE]; // see R02
    assign osc_type_select_o = wsc_pkg::wsc_osc_t'(cfg[wsc_pkg::CFG_OSC_HI:wsc_pkg::CFG_OSC_LO]); // see R03
    assign code_protect_o = MULTI_PROTECT ?
        !(&cfg[wsc_pkg::CFG_CP_HI:wsc_pkg::CFG_CP_LO]) :
        !cfg[wsc_pkg::CFG_CP_SINGLE]; // see R01
    assign prescaler_assign = option_control[wsc_pkg::OPT_PSA];
    assign prescale_ratio = option_control[wsc_pkg::OPT_PS_HI:wsc_pkg::OPT_PS_LO]; // see R09
    assign wdt_mask = wsc_pkg::PSC_W'((9'h001 << prescale_ratio) - 9'h001); // see R19
    assign tmr_mask = wsc_pkg::PSC_W'((9'h002 << prescale_ratio) - 9'h001);

    ////////////////////////////////////////////////////////////////////////////
    // event decode
    assign sleep_entry = sleep_instr_i && (state == wsc_pkg::ST_RUN);
    assign base_tick = watchdog_enable_fuse && (base_cnt == wsc_pkg::WDT_CNT_W'(WDT_BASE - 1));
    assign wdt_timeout = base_tick && !wdt_clear &&
        (!prescaler_assign || ((psc & wdt_mask) == wdt_mask)); // see R10
    assign wake = (state == wsc_pkg::ST_SLEEP) && (wdt_timeout || master_clear_pin_fall);
    assign any_reset = wdt_timeout || master_clear_pin_fall; // see R05
    assign wdt_clear = watchdog_clear_instr_instr_i || sleep_entry || master_clear_pin_fall; // see R11, R12
    assign irq_event = {master_clear_pin_fall, sleep_entry, wdt_timeout};

    ////////////////////////////////////////////////////////////////////////////
    // watchdog base counter on its own free-running time base
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            base_cnt <= '0;
        end else if (!watchdog_enable_fuse) begin
            base_cnt <= '0; // see R07
        end else if (wdt_clear || wake || base_tick) begin
            base_cnt <= '0; // see R18
        end else begin
            base_cnt <= base_cnt + 1'b1; // see R04
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared prescaler
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            psc <= wsc_pkg::PSC_RESET;
        end else if (any_reset) begin
            psc <= wsc_pkg::PSC_RESET; // see R17
        end else if (prescaler_assign) begin
            if (wdt_clear) begin
                psc <= wsc_pkg::PSC_RESET; // see R11, R12
            end else if (base_tick) begin
                psc <= psc + 1'b1; // see R08, R16
            end
        end else begin
            if (tmr_write_i) begin
                psc <= wsc_pkg::PSC_RESET;
            end else if (tmr_src_tick_i) begin
                psc <= psc + 1'b1; // see R08, R16
            end
        end
    end

    assign tmr_inc_o = prescaler_assign ? tmr_src_tick_i :
        (tmr_src_tick_i && !tmr_write_i && ((psc & tmr_mask) == tmr_mask)); // see R16

    ////////////////////////////////////////////////////////////////////////////
    // sleep state, oscillator driver and port hold
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= wsc_pkg::ST_RUN;
        end else begin
            unique case (state)
                wsc_pkg::ST_RUN: begin
                    if (sleep_entry && !any_reset) begin
                        state <= wsc_pkg::ST_SLEEP;
                    end
                end
                wsc_pkg::ST_SLEEP: begin
                    if (wake) begin
                        state <= wsc_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    assign sleeping_o = (state == wsc_pkg::ST_SLEEP);
    assign osc_drv_en_o = !sleeping_o; // see R13

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_out_o <= '0;
            port_oe_o <= '0;
        end else if (!sleeping_o) begin
            port_out_o <= port_out_i;
            port_oe_o <= port_oe_i;
        end
    end // see R14

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            device_reset_o <= 1'b0;
        end else begin
            device_reset_o <= any_reset; // see R05
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end else if (wdt_timeout) begin
            timeout_flag_n <= 1'b0; // see R06
        end else if (sleep_entry && !master_clear_pin_fall) begin
            timeout_flag_n <= 1'b1; // see R13
            powerdown_flag_n <= 1'b0; // see R13
        end else if (watchdog_clear_instr_instr_i && !master_clear_pin_fall) begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration word, writable once after power-on
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg <= wsc_pkg::CFG_RESET;
            cfg_locked <= 1'b0;
        end else if (wr_i && addr_i == wsc_pkg::REG_CONFIG && !cfg_locked) begin
            cfg <= MULTI_PROTECT ? wdata_i[wsc_pkg::CFG_W-1:0] :
                (wdata_i[wsc_pkg::CFG_W-1:0] & wsc_pkg::CFG_SINGLE_MASK);
            cfg_locked <= 1'b1; // see R07
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // option register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            option_control <= wsc_pkg::OPT_RESET;
        end else if (any_reset) begin
            option_control <= wsc_pkg::OPT_RESET;
        end else if (wr_i && addr_i == wsc_pkg::REG_OPTION) begin
            option_control <= wdata_i[wsc_pkg::OPT_W-1:0] & wsc_pkg::OPT_IMPL_MASK; // see R09
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask, set wins over write-one-to-clear
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat <= wsc_pkg::IRQ_RESET;
        end else if (wr_i && addr_i == wsc_pkg::REG_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~wdata_i[wsc_pkg::IRQ_W-1:0]) | irq_event;
        end else begin
            irq_stat <= irq_stat | irq_event;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_mask <= wsc_pkg::IRQ_RESET;
        end else if (wr_i && addr_i == wsc_pkg::REG_IRQ_MASK) begin
            irq_mask <= wdata_i[wsc_pkg::IRQ_W-1:0];
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            unique case (addr_i)
                wsc_pkg::REG_CONFIG: rdata_o <= wsc_pkg::DATA_W'(cfg);
                wsc_pkg::REG_OPTION: rdata_o <= wsc_pkg::DATA_W'(option_control);
                wsc_pkg::REG_STATUS: begin
                    rdata_o <= '0;
                    rdata_o[wsc_pkg::STAT_TO_N] <= timeout_flag_n;
                    rdata_o[wsc_pkg::STAT_PD_N] <= powerdown_flag_n;
                    rdata_o[wsc_pkg::STAT_SLEEP] <= sleeping_o;
                    rdata_o[wsc_pkg::STAT_WDT_ON] <= watchdog_enable_fuse;
                end
                wsc_pkg::REG_IRQ_STAT: rdata_o <= wsc_pkg::DATA_W'(irq_stat);
                wsc_pkg::REG_IRQ_MASK: rdata_o <= wsc_pkg::DATA_W'(irq_mask);
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // base ticks counted since the watchdog and its postscaler were last cleared
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ticks_seen <= '0;
        end else if (any_reset || wdt_clear || !prescaler_assign) begin
            ticks_seen <= '0;
        end else if (base_tick) begin
            ticks_seen <= ticks_seen + 1'b1;
        end
    end

    sequence s_sleep_req;
        sleep_entry && !any_reset;
    endsequence

    sequence s_sleep_state;
        sleeping_o && timeout_flag_n && !powerdown_flag_n && !osc_drv_en_o;
    endsequence

    chk_timeout_reset_out: assert property (wdt_timeout |=> device_reset_o) // see R05
        else $error("time-out gave no device reset");
    chk_timeout_flag_clr: assert property (wdt_timeout |=> !timeout_flag_n && psc == 8'h00) // see R06
        else $error("time-out flag or prescaler wrong after time-out");
    chk_fuse_off_idle: assert property (!watchdog_enable_fuse |-> !wdt_timeout ##1 base_cnt == 0) // see R07
        else $error("watchdog active with fuse off");
    chk_sleep_entry_flags: assert property (s_sleep_req |=> s_sleep_state) // see R13
        else $error("sleep entry flags wrong");
    chk_io_hold: assert property (sleeping_o && $past(sleeping_o) |-> $stable(port_out_o) && $stable(port_oe_o)) // see R14
        else $error("port changed during sleep");
    chk_master_clear_pin_not_driven: assert property (!master_clear_pin_oe_o) // see R15
        else $error("master clear pin driven");
    chk_clear_counter: assert property (watchdog_clear_instr_instr_i |=> base_cnt == 0 && (!$past(prescaler_assign) || psc == 8'h00)) // see R11
        else $error("watchdog clear missed");
    chk_sleep_clear: assert property (s_sleep_req ##1 1'b1 |-> base_cnt == 0) // see R12
        else $error("sleep did not clear watchdog");
    chk_wake_clear: assert property (wake |=> base_cnt == 0 && !sleeping_o) // see R18
        else $error("wake did not clear watchdog");
    chk_ratio_period: assert property (wdt_timeout && prescaler_assign |->
        ticks_seen == (9'h001 << prescale_ratio) - 9'h001) // see R19
        else $error("time-out before ratio reached");
    chk_psc_reset_zero: assert property (device_reset_o |-> psc == 8'h00) // see R17
        else $error("prescaler not zero after reset");
endmodule

// ===== design/wsc_pkg.sv
// constants, types and register map of the watchdog, sleep and configuration block
package wsc_pkg;
    // register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_OPTION = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_IRQ_STAT = 4'h3;
    localparam logic [3:0] REG_IRQ_MASK = 4'h4;
    // configuration word layout
    localparam int CFG_W = 12;
    localparam int CFG_CP_HI = 11;
    localparam int CFG_CP_LO = 3;
    localparam int CFG_CP_SINGLE = 3;
    localparam int CFG_WATCHDOG_ENABLE_FUSE = 2;
    localparam int CFG_OSC_HI = 1;
    localparam int CFG_OSC_LO = 0;
    localparam logic [11:0] CFG_RESET = 12'hfff;
    localparam logic [11:0] CFG_SINGLE_MASK = 12'h00f;
    // option register layout
    localparam int OPT_W = 8;
    localparam int OPT_PSA = 3;
    localparam int OPT_PS_HI = 2;
    localparam int OPT_PS_LO = 0;
    localparam logic [7:0] OPT_RESET = 8'h3f;
    localparam logic [7:0] OPT_IMPL_MASK = 8'h3f;
    // status register layout
    localparam int STAT_TO_N = 4;
    localparam int STAT_PD_N = 3;
    localparam int STAT_SLEEP = 1;
    localparam int STAT_WDT_ON = 0;
    // interrupt bits
    localparam int IRQ_W = 3;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_SLEEP = 1;
    localparam int IRQ_MASTER_CLEAR_PIN = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // prescaler
    localparam int PSC_W = 8;
    localparam logic [7:0] PSC_RESET = 8'h00;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int WDT_NOM_MS = 18;
    localparam int WDT_BASE_CYCLES = (WDT_NOM_MS * 1000000) / CLK_PERIOD_NS;
    localparam int WDT_CNT_W = 32;
    // oscillator types and run/sleep state
    typedef enum logic [1:0] {
        OSC_LP = 2'b00,
        OSC_XT = 2'b01,
        OSC_HS = 2'b10,
        OSC_RC = 2'b11
    } wsc_osc_t;
    typedef enum logic {
        ST_RUN = 1'b0,
        ST_SLEEP = 1'b1
    } wsc_state_t;
endpackage

// ===== design/wsc_sync2.sv
// two flip-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module wsc_sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic async_i,
    output logic sync_o
);
    logic stage1;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stage1 <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule

// ===== bench/tb.sv
// self-checking testbench of the watchdog, sleep and configuration block
`timescale 1ns/1ps
module tb;
    localparam int WB = 20;
    localparam int IO_W = 8;
    logic clk_sys_i;
    logic rstn_i;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr, rd, watchdog_clear_instr, sleep, tick, tmr_wr, master_clear_pin_n;
    logic [IO_W-1:0] pout, poe, pout_o, poe_o;
    logic [15:0] rdata;
    logic [15:0] got;
    logic tmr_inc, mc_o, mc_oe, dev_rst, sleeping, osc_en, cprot, irq;
    wsc_pkg::wsc_osc_t osc_sel;
    int error_cnt, cmp_count, inc_cnt, rst_cnt, oe_bad, cyc, t0, base;

    wsc_watchdog #(.WDT_BASE(WB), .MULTI_PROTECT(1'b1), .IO_W(IO_W)) wsc_watchdog_inst (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .watchdog_clear_instr_instr_i(watchdog_clear_instr),
        .sleep_instr_i(sleep), .tmr_src_tick_i(tick), .tmr_write_i(tmr_wr),
        .tmr_inc_o(tmr_inc), .master_clear_pin_i(master_clear_pin_n), .master_clear_pin_o(mc_o),
        .master_clear_pin_oe_o(mc_oe), .port_out_i(pout), .port_oe_i(poe),
        .port_out_o(pout_o), .port_oe_o(poe_o), .device_reset_o(dev_rst),
        .sleeping_o(sleeping), .osc_drv_en_o(osc_en), .osc_type_select_o(osc_sel),
        .code_protect_o(cprot), .irq_o(irq));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        cyc++;
        if (tmr_inc === 1'b1) inc_cnt++;
        if (dev_rst === 1'b1) rst_cnt++;
        if (mc_oe !== 1'b0) oe_bad++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_num(input string what, input int exp, input int seen);
        cmp_count++;
        if (seen != exp) begin
            error_cnt++;
            $display("Error %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
        #1;
    endtask

    task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic read_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        read_reg(a, d);
        chk_val(what, exp, d);
    endtask

    // one-cycle instruction pulse: 0 clear, 1 sleep; start of timing taken after it
    task automatic pulse(input int which);
        @(posedge clk_sys_i);
        if (which == 0) watchdog_clear_instr <= 1'b1;
        else sleep <= 1'b1;
        @(posedge clk_sys_i);
        watchdog_clear_instr <= 1'b0;
        sleep <= 1'b0;
        #1;
        t0 = cyc;
    endtask

    task automatic wait_rst(input int exp);
        while (dev_rst !== 1'b1 && cyc - t0 < exp + 50) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk_num("time-out cycles", exp, cyc - t0 + 1);
    endtask

    task automatic ticks(input int cnt);
        repeat (cnt) begin
            @(posedge clk_sys_i);
            tick <= 1'b1;
            @(posedge clk_sys_i);
            tick <= 1'b0;
        end
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 30000);
        error_cnt++;
        give_verdict();
    end

    initial begin
        rstn_i = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        {wr, rd, watchdog_clear_instr, sleep, tick, tmr_wr} = 6'h00;
        master_clear_pin_n = 1'b1;
        pout = 8'ha5;
        poe = 8'h0f;
        {error_cnt, cmp_count, inc_cnt, rst_cnt, oe_bad, cyc, t0} = '0;
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        // reset values and an unmapped place
        read_chk("option", wsc_pkg::REG_OPTION, 16'h003f);
        read_chk("config", wsc_pkg::REG_CONFIG, 16'h0fff);
        read_chk("status", wsc_pkg::REG_STATUS, 16'h0019);
        read_chk("unmapped", 4'h7, 16'h0000);
        chk_val("osc type", 16'h0003, {14'h0, osc_sel});
        chk_val("protect", 16'h0000, {15'h0, cprot});
        // regular clearing holds off the time-out
        write_reg(wsc_pkg::REG_OPTION, 16'h0030);
        base = rst_cnt;
        repeat (5) begin
            pulse(0);
            repeat (WB - 4) @(posedge clk_sys_i);
        end
        chk_num("no reset", base, rst_cnt);
        // prescaler on the general timer divides by two, on the watchdog passes through
        pulse(0);
        @(posedge clk_sys_i);
        tmr_wr <= 1'b1;
        @(posedge clk_sys_i);
        tmr_wr <= 1'b0;
        base = inc_cnt;
        ticks(4);
        chk_num("timer div", 2, inc_cnt - base);
        pulse(0);
        write_reg(wsc_pkg::REG_OPTION, 16'h0038);
        base = inc_cnt;
        ticks(4);
        chk_num("timer pass", 4, inc_cnt - base);
        // time-out periods, without and with the postscaler at every ratio
        write_reg(wsc_pkg::REG_OPTION, 16'h0037);
        pulse(0);
        wait_rst(WB + 1);
        for (int r = 0; r < 8; r++) begin
            write_reg(wsc_pkg::REG_OPTION, 16'h0008 | 16'(r));
            pulse(0);
            wait_rst(WB * (1 << r) + 1);
        end
        read_chk("status", wsc_pkg::REG_STATUS, 16'h0009);
        read_chk("option", wsc_pkg::REG_OPTION, 16'h003f);
        read_chk("irq stat", wsc_pkg::REG_IRQ_STAT, 16'h0001);
        chk_val("irq masked", 16'h0000, {15'h0, irq});
        write_reg(wsc_pkg::REG_IRQ_MASK, 16'h0007);
        chk_val("irq on", 16'h0001, {15'h0, irq});
        write_reg(wsc_pkg::REG_IRQ_STAT, 16'h0001);
        chk_val("irq cleared", 16'h0000, {15'h0, irq});
        // sleep: flags, frozen ports, wake by time-out after the full period
        pulse(1);
        chk_val("sleeping", 16'h0001, {15'h0, sleeping});
        chk_val("osc driver", 16'h0000, {15'h0, osc_en});
        @(posedge clk_sys_i);
        pout <= 8'h5a;
        poe <= 8'hf0;
        read_chk("status", wsc_pkg::REG_STATUS, 16'h0013);
        chk_val("port out", 16'h00a5, {8'h0, pout_o});
        chk_val("port oe", 16'h000f, {8'h0, poe_o});
        wait_rst(WB * 128 + 1);
        @(posedge clk_sys_i);
        #1;
        chk_val("awake", 16'h0000, {15'h0, sleeping});
        read_chk("status", wsc_pkg::REG_STATUS, 16'h0001);
        read_chk("irq stat", wsc_pkg::REG_IRQ_STAT, 16'h0003);
        // external master clear gives a reset, the pin itself is never driven
        @(posedge clk_sys_i);
        master_clear_pin_n <= 1'b0;
        #1;
        t0 = cyc;
        while (dev_rst !== 1'b1 && cyc - t0 < 8) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk_val("master_clear_pin reset", 16'h0001, {15'h0, dev_rst});
        chk_num("master_clear_pin delay", 3, cyc - t0);
        chk_val("pin level", 16'h0000, {15'h0, mc_o});
        @(posedge clk_sys_i);
        master_clear_pin_n <= 1'b1;
        read_chk("irq stat", wsc_pkg::REG_IRQ_STAT, 16'h0007);
        chk_num("pin drive", 0, oe_bad);
        // configuration word: every oscillator code, protection and fuse off
        for (int c = 0; c < 4; c++) begin
            do_reset();
            write_reg(wsc_pkg::REG_CONFIG, 16'h0ff0 | 16'(c));
            chk_val("osc type", 16'(c), {14'h0, osc_sel});
            chk_val("protect", 16'h0001, {15'h0, cprot});
        end
        write_reg(wsc_pkg::REG_CONFIG, 16'h0fff);
        read_chk("config", wsc_pkg::REG_CONFIG, 16'h0ff3);
        read_chk("status", wsc_pkg::REG_STATUS, 16'h0018);
        write_reg(wsc_pkg::REG_OPTION, 16'h0008);
        base = rst_cnt;
        repeat (5 * WB) @(posedge clk_sys_i);
        chk_num("fuse off", base, rst_cnt);
        give_verdict();
    end
endmodule
